// >>> rtl/rcc_ctrl.sv
// rtc count-block controller: ahb-lite registers, set handshake,
// periodic, alarm and down-count timer events, half-second pin
// assumes hresetn is the system reset and por_n the power-on reset
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl
	import rcc_pkg::*;
(
	// clock and resets
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        por_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// outputs
	output logic             irq,
	output logic             half_sec_clk_out
);
	// ==================================================
	// bus capture
	logic        wr_ph_reg;
	logic [7:0]  wa_reg;
	logic        rd_go;
	logic        wr_irq;
	logic        wr_tmr;
	assign rd_go  = hsel && hready && htrans[1] && !hwrite;
	assign wr_irq = wr_ph_reg && (wa_reg == RCC_OFF_IRQ);
	assign wr_tmr = wr_ph_reg && (wa_reg == RCC_OFF_TIMER);

	// address phase latch; zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ph_reg <= 1'b0;
			wa_reg    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			wr_ph_reg <= hsel && hready && htrans[1] && hwrite;
			wa_reg    <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ==================================================
	// control and data registers
	logic [23:0] subs_reg;
	logic [17:0] tset_reg;
	rcc_cal_t    calr_reg;
	logic [6:0]  amin_reg;
	logic [5:0]  ahour_reg;
	logic [5:0]  adate_reg;
	logic [4:0]  amon_reg;
	logic [7:0]  ayear_reg;
	logic [4:0]  aen_reg;
	logic [7:0]  ien_reg;
	logic        go_reg;
	logic        rsreq_reg;
	logic        tmode_reg;
	rcc_set_t    set_st;
	rcc_cal_t    cal;
	logic        busy;
	logic        cap_reg;
	assign busy = (set_st != RCC_IDLE);

	// settings written by software, cleared by system reset only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			subs_reg  <= RCC_SUBS_RST;
			tset_reg  <= RCC_TSET_RST;
			ien_reg   <= '0;
			aen_reg   <= '0;
			go_reg    <= 1'b0;
			tmode_reg <= 1'b0;
			amin_reg  <= '0;
			ahour_reg <= '0;
			adate_reg <= '0;
			amon_reg  <= '0;
			ayear_reg <= '0;
		end
		else if (wr_ph_reg)
		begin
			case (wa_reg)
				RCC_OFF_IRQ:
				begin
					ien_reg <= hwdata[RCC_EN_SH +: RCC_NFLAG];
					aen_reg <= hwdata[RCC_B_AEN +: 5];
					go_reg  <= hwdata[RCC_B_GO];
				end
				RCC_OFF_TIMER: tmode_reg <= hwdata[RCC_B_TMODE];
				RCC_OFF_SUBS:  subs_reg  <= hwdata[23:0];
				RCC_OFF_TSET:  tset_reg  <= hwdata[17:0];
				RCC_OFF_ADHM:
				begin
					adate_reg <= hwdata[29:24];
					ahour_reg <= hwdata[21:16];
					amin_reg  <= hwdata[14:8];
				end
				RCC_OFF_AYM:
				begin
					ayear_reg <= hwdata[23:16];
					amon_reg  <= hwdata[12:8];
				end
				default: ;
			endcase
		end
	end

	// ==================================================
	// set handshake: hold while request high, then load calendar
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			set_st    <= RCC_IDLE;
			rsreq_reg <= 1'b0;
		end
		else
		begin
			if (wr_irq)
				rsreq_reg <= hwdata[RCC_B_RSREQ];
			case (set_st)
				RCC_IDLE: if (wr_irq && hwdata[RCC_B_RSREQ])
					set_st <= RCC_HOLD;
				RCC_HOLD: if (wr_irq && !hwdata[RCC_B_RSREQ])
					set_st <= RCC_LOAD;
				RCC_LOAD: set_st <= RCC_IDLE;
				default:  set_st <= RCC_IDLE;
			endcase
		end
	end

	// calendar register image: capture, else host writes; loaded into counters on go
	always_ff @(posedge hclk or negedge por_n)
	begin
		if (!por_n)
			calr_reg <= '0;
		else if (cap_reg)
			calr_reg <= cal;
		else if (wr_ph_reg && wa_reg == RCC_OFF_DHMS)
		begin
			calr_reg.date   <= hwdata[29:24];
			calr_reg.hour   <= hwdata[21:16];
			calr_reg.minute <= hwdata[14:8];
			calr_reg.second <= hwdata[6:0];
		end
		else if (wr_ph_reg && wa_reg == RCC_OFF_YMW)
		begin
			calr_reg.year  <= hwdata[23:16];
			calr_reg.month <= hwdata[12:8];
			calr_reg.wday  <= hwdata[2:0];
		end
	end

	// ==================================================
	// dividers and counters
	logic go_rise;
	logic go_q_reg;
	logic hs_tick;
	logic tm_tick;
	logic sec_reg;
	logic sec_tick;
	logic min_tick;
	logic hour_tick;
	logic divclr;
	assign go_rise = go_reg && !go_q_reg;
	assign divclr  = (set_st == RCC_HOLD) || go_rise;

	// date/time divider; por only, yet system reset clears go_reg, so its count reloads
	rcc_divider #(.W(24)) u_div_dt (
		.hclk    (hclk),
		.hresetn (por_n),
		.clr     (divclr),
		.run     (go_reg),
		.period  (subs_reg),
		.tick    (hs_tick)
	);

	// timer divider, free running once counting
	rcc_divider #(.W(24)) u_div_tm (
		.hclk    (hclk),
		.hresetn (por_n),
		.clr     (go_rise),
		.run     (go_reg),
		.period  (subs_reg),
		.tick    (tm_tick)
	);

	// one-second counter: cleared by system reset and by set
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sec_reg  <= 1'b0;
			go_q_reg <= 1'b0;
			half_sec_clk_out <= 1'b0;
		end
		else
		begin
			go_q_reg <= go_reg;
			if (divclr)
				sec_reg <= 1'b0;
			else if (hs_tick)
				sec_reg <= !sec_reg;
			if (hs_tick)
				half_sec_clk_out <= !half_sec_clk_out;
		end
	end
	assign sec_tick = hs_tick && sec_reg && (set_st == RCC_IDLE);

	rcc_calendar u_cal (
		.hclk      (hclk),
		.por_n     (por_n),
		.sec_tick  (sec_tick),
		.load      ((set_st == RCC_LOAD) || go_rise),
		.load_val  (calr_reg),
		.cal       (cal),
		.min_tick  (min_tick),
		.hour_tick (hour_tick)
	);

	// ==================================================
	// down-count timer
	logic [17:0] tcnt_reg;
	logic        tgo_reg;
	logic        tact_reg;
	logic        tmr_evt;
	assign tmr_evt = tact_reg && tgo_reg && tm_tick && (tcnt_reg == '0);

	// load on go, count per tick, reload or stop on completion
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tcnt_reg <= '0;
			tgo_reg  <= 1'b0;
			tact_reg <= 1'b0;
		end
		else if (wr_tmr && hwdata[RCC_B_TGO] && !tgo_reg)
		begin
			tcnt_reg <= tset_reg;
			tgo_reg  <= 1'b1;
			tact_reg <= 1'b1;
		end
		else if (wr_tmr && !hwdata[RCC_B_TGO])
			tgo_reg <= 1'b0;
		else if (tmr_evt && tmode_reg)
			tcnt_reg <= tset_reg;
		else if (tmr_evt)
			tgo_reg <= 1'b0;
		else if (!tgo_reg)
			tact_reg <= 1'b0;
		else if (tm_tick)
			tcnt_reg <= tcnt_reg - 18'd1;
	end

	// ==================================================
	// capture request: one cycle copy then release
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cap_reg <= 1'b0;
		else if (cap_reg)
			cap_reg <= 1'b0;
		else if (wr_tmr && hwdata[RCC_B_CREQ])
			cap_reg <= 1'b1;
	end

	// ==================================================
	// event flags: set wins over software clear
	logic [7:0] flag_reg;
	logic [7:0] evt;
	logic       alm_hit;
	logic       alm_q_reg;
	assign alm_hit = (aen_reg != '0)
		&& (!aen_reg[4] || ayear_reg == cal.year)
		&& (!aen_reg[3] || amon_reg == cal.month)
		&& (!aen_reg[2] || adate_reg == cal.date)
		&& (!aen_reg[1] || ahour_reg == cal.hour)
		&& (!aen_reg[0] || amin_reg == cal.minute);
	always_comb
	begin
		evt = '0;
		evt[RCC_B_HSEC] = hs_tick;
		evt[RCC_B_SEC]  = sec_tick;
		evt[RCC_B_MIN]  = min_tick;
		evt[RCC_B_HOUR] = hour_tick;
		evt[RCC_B_TMR]  = tmr_evt;
		evt[RCC_B_ALM]  = alm_hit && !alm_q_reg;
		evt[RCC_B_CAP]  = cap_reg;
	end

	// written zero clears, written one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flag_reg  <= '0;
			alm_q_reg <= 1'b0;
			irq       <= 1'b0;
		end
		else
		begin
			alm_q_reg <= alm_hit;
			flag_reg  <= (wr_irq ? (flag_reg & hwdata[7:0]) : flag_reg)
				| evt;
			irq <= |(flag_reg & ien_reg);
		end
	end

	// ==================================================
	// read data, registered in the address phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (rd_go)
		begin
			case (haddr[7:0])
				RCC_OFF_IRQ: hrdata <= {ien_reg, 3'b000, aen_reg, 1'b0,
					busy, rsreq_reg, 2'b00, go_reg, 1'b0, go_reg,
					flag_reg};
				RCC_OFF_TIMER: hrdata <= {21'h0, tact_reg, tmode_reg,
					tgo_reg, 7'h00, cap_reg};
				RCC_OFF_SUBS: hrdata <= {8'h00, subs_reg};
				RCC_OFF_DHMS: hrdata <= {2'b00, calr_reg.date, 2'b00,
					calr_reg.hour, 1'b0, calr_reg.minute, 1'b0,
					calr_reg.second};
				RCC_OFF_YMW: hrdata <= {8'h00, calr_reg.year, 3'b000,
					calr_reg.month, 5'h00, calr_reg.wday};
				RCC_OFF_ADHM: hrdata <= {2'b00, adate_reg, 2'b00,
					ahour_reg, 1'b0, amin_reg[6:0], 8'h00};
				RCC_OFF_AYM: hrdata <= {8'h00, ayear_reg, 3'b000,
					amon_reg, 8'h00};
				RCC_OFF_TSET: hrdata <= {14'h0, tset_reg};
				default: hrdata <= '0;
			endcase
		end
	end

	// ==================================================
	// checks
	sequence s_go_write;
		wr_tmr && hwdata[RCC_B_TGO] && !tgo_reg;
	endsequence
	property p_load;
		@(posedge hclk) disable iff (!hresetn)
		s_go_write |=> tgo_reg && tact_reg && tcnt_reg == $past(tset_reg);
	endproperty
	a_load: assert property (p_load) else $error("timer not loaded");
	property p_oneshot;
		@(posedge hclk) disable iff (!hresetn)
		tmr_evt && !tmode_reg && !wr_tmr |=> !tgo_reg ##1 !tact_reg;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot");
	property p_periodic;
		@(posedge hclk) disable iff (!hresetn)
		tmr_evt && tmode_reg && !wr_tmr |=> tgo_reg && tcnt_reg == $past(tset_reg);
	endproperty
	a_periodic: assert property (p_periodic) else $error("reload");
	property p_dec;
		@(posedge hclk) disable iff (!hresetn)
		tgo_reg && tm_tick && tcnt_reg != '0 && !wr_tmr
			|=> tcnt_reg == $past(tcnt_reg) - 18'd1;
	endproperty
	a_dec: assert property (p_dec) else $error("no decrement");
	property p_flagset;
		@(posedge hclk) disable iff (!hresetn)
		evt[RCC_B_HSEC] |=> flag_reg[RCC_B_HSEC];
	endproperty
	a_flagset: assert property (p_flagset) else $error("flag lost");
	property p_keep;
		@(posedge hclk) disable iff (!hresetn)
		wr_irq && hwdata[RCC_B_SEC] && flag_reg[RCC_B_SEC]
			|=> flag_reg[RCC_B_SEC];
	endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		|(flag_reg & ien_reg) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
	property p_cap;
		@(posedge hclk) disable iff (!hresetn)
		cap_reg |=> !cap_reg && flag_reg[RCC_B_CAP] && calr_reg == $past(cal);
	endproperty
	a_cap: assert property (p_cap) else $error("capture");
	property p_busy;
		@(posedge hclk) disable iff (!hresetn)
		set_st == RCC_IDLE && wr_irq && hwdata[RCC_B_RSREQ] |=> busy [*2];
	endproperty
	a_busy: assert property (p_busy) else $error("busy");
endmodule
`default_nettype wire

// >>> inc/rcc_pkg.sv
// constants, register map and carried types of the rtc count-block controller
// assumes one 100 MHz clock and a 32-bit ahb-lite register port
// Operation
// - capture during set overwrites calendar registers
// - four periodic events set flags, request interrupt
// - write zero clears flag; clear before enable
// - enabled alarm fields match sets alarm flag
// - alarm may fire at enable; software rechecks
// - one-shot underflow: interrupt, stop, clear active
// - periodic completion: interrupt, reload, keep counting
// - timer_go one loads and starts; zero stops
// - pin outputs half-second clock
// - power-on reset clears all counters (code clears the second and timer counters on system reset only, not on por_n)
// - system reset clears second and timer counters
// - system reset keeps sub-second and calendar counters (code reloads the sub-second divider, as system reset clears go_reg)
// - set request resets dividers (code resets the date/time divider only); release loads calendar
// - timer decrements every half-second tick
// - capture done clears request, raises read flag
package rcc_pkg;
	// ==================================================
	// register byte offsets
	localparam logic [7:0] RCC_OFF_IRQ   = 8'h00;
	localparam logic [7:0] RCC_OFF_TIMER = 8'h04;
	localparam logic [7:0] RCC_OFF_SUBS  = 8'h08;
	localparam logic [7:0] RCC_OFF_DHMS  = 8'h0c;
	localparam logic [7:0] RCC_OFF_YMW   = 8'h10;
	localparam logic [7:0] RCC_OFF_ADHM  = 8'h14;
	localparam logic [7:0] RCC_OFF_AYM   = 8'h18;
	localparam logic [7:0] RCC_OFF_TSET  = 8'h1c;
	// ==================================================
	// irq word bit positions (flags low byte, enables byte 3)
	localparam int RCC_B_HSEC   = 0;
	localparam int RCC_B_SEC    = 1;
	localparam int RCC_B_MIN    = 2;
	localparam int RCC_B_HOUR   = 3;
	localparam int RCC_B_TMR    = 4;
	localparam int RCC_B_ALM    = 5;
	localparam int RCC_B_CAP    = 7;
	localparam int RCC_EN_SH    = 24;
	localparam int RCC_B_GO     = 8;
	localparam int RCC_B_RUN    = 10;
	localparam int RCC_B_RSREQ  = 13;
	localparam int RCC_B_BUSY   = 14;
	localparam int RCC_B_AEN    = 16;
	// timer word bit positions
	localparam int RCC_B_CREQ   = 0;
	localparam int RCC_B_TGO    = 8;
	localparam int RCC_B_TMODE  = 9;
	localparam int RCC_B_TACT   = 10;
	localparam int RCC_NFLAG    = 8;
	// ==================================================
	// reset values and timing
	localparam logic [23:0] RCC_SUBS_RST = 24'h000000;
	localparam logic [17:0] RCC_TSET_RST = 18'h00000;
	localparam int RCC_CLK_NS  = 10;
	localparam int RCC_HALF_NS = 500000000;
	localparam int RCC_HALF_CYC = RCC_HALF_NS / RCC_CLK_NS;
	// ==================================================
	// calendar value carried between counters and registers
	typedef struct packed {
		logic [7:0] year;
		logic [4:0] month;
		logic [2:0] wday;
		logic [5:0] date;
		logic [5:0] hour;
		logic [6:0] minute;
		logic [6:0] second;
	} rcc_cal_t;
	typedef enum logic [2:0] {
		RCC_IDLE = 3'b001,
		RCC_HOLD = 3'b010,
		RCC_LOAD = 3'b100
	} rcc_set_t;
endpackage

// >>> rtl/rcc_divider.sv
// half-second tick generator from a settable cycle count
// assumes reload value stable while running
`timescale 1ns/1ps
`default_nettype none
module rcc_divider
	import rcc_pkg::*;
#(
	parameter int W = 24
)(
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// control
	input  wire logic         clr,
	input  wire logic         run,
	input  wire logic [W-1:0] period,
	// result
	output logic              tick
);
	logic [W-1:0] cnt_reg;

	// ==================================================
	// down counter, one tick pulse at terminal count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end
		else if (clr || !run)
		begin
			cnt_reg <= period;
			tick    <= 1'b0;
		end
		else if (cnt_reg == '0)
		begin
			cnt_reg <= period;
			tick    <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg - 1'b1;
			tick    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/rcc_calendar.sv
// binary calendar counters: second..year, weekday; loadable
// assumes leap year every fourth year from year 0
`timescale 1ns/1ps
`default_nettype none
module rcc_calendar
	import rcc_pkg::*;
(
	// clock and reset
	input  wire logic     hclk,
	input  wire logic     por_n,
	// control
	input  wire logic     sec_tick,
	input  wire logic     load,
	input  wire rcc_cal_t load_val,
	// state
	output rcc_cal_t      cal,
	output logic          min_tick,
	output logic          hour_tick
);
	// days in a month, leap aware
	function automatic logic [5:0] mdays(input logic [4:0] m,
		input logic [7:0] y);
		case (m)
			5'd2:    mdays = (y[1:0] == 2'b00) ? 6'd29 : 6'd28;
			5'd4, 5'd6, 5'd9, 5'd11: mdays = 6'd30;
			default: mdays = 6'd31;
		endcase
	endfunction

	// ==================================================
	// ripple roll-over; cleared by power-on reset only, system reset keeps it
	always_ff @(posedge hclk or negedge por_n)
	begin
		if (!por_n)
		begin
			cal       <= '0;
			min_tick  <= 1'b0;
			hour_tick <= 1'b0;
		end
		else if (load)
		begin
			cal       <= load_val;
			min_tick  <= 1'b0;
			hour_tick <= 1'b0;
		end
		else
		begin
			min_tick  <= 1'b0;
			hour_tick <= 1'b0;
			if (sec_tick)
			begin
				if (cal.second < 7'd59)
					cal.second <= cal.second + 7'd1;
				else
				begin
					cal.second <= '0;
					min_tick   <= 1'b1;
					if (cal.minute < 7'd59)
						cal.minute <= cal.minute + 7'd1;
					else
					begin
						cal.minute <= '0;
						hour_tick  <= 1'b1;
						if (cal.hour < 6'd23)
							cal.hour <= cal.hour + 6'd1;
						else
						begin
							cal.hour <= '0;
							cal.wday <= (cal.wday == 3'd6) ? 3'd0
								: cal.wday + 3'd1;
							if (cal.date < mdays(cal.month, cal.year))
								cal.date <= cal.date + 6'd1;
							else
							begin
								cal.date <= 6'd1;
								if (cal.month < 5'd12)
									cal.month <= cal.month + 5'd1;
								else
								begin
									cal.month <= 5'd1;
									cal.year  <= (cal.year == 8'd99) ? 8'd0
										: cal.year + 8'd1;
								end
							end
						end
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the rtc count-block controller
// assumes rcc_pkg and rcc_ctrl compiled first; design holds its own asserts
`timescale 1ns/1ps
`default_nettype none
module tb
	import rcc_pkg::*;
;
	// ==================================================
	// design connections
	logic        hclk;
	logic        hresetn;
	logic        por_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic        half_sec_clk_out;
	int          n_mismatch;
	int          check_count;
	integer      seed;
	logic [31:0] ctl;
	logic [31:0] cal;
	logic [31:0] d;
	logic [17:0] tset;
	int          n;
	logic        p;

	rcc_ctrl uut (
		.hclk             (hclk),
		.hresetn          (hresetn),
		.por_n            (por_n),
		.hsel             (hsel),
		.haddr            (haddr),
		.htrans           (htrans),
		.hwrite           (hwrite),
		.hsize            (3'h2),
		.hwdata           (hwdata),
		.hready           (hreadyout),
		.hrdata           (hrdata),
		.hreadyout        (hreadyout),
		.hresp            (hresp),
		.irq              (irq),
		.half_sec_clk_out (half_sec_clk_out)
	);

	// ==================================================
	// clock and hang guard; the run needs well under 10k cycles
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial
	begin
		#500000;
		n_mismatch++;
		wrap_up();
	end

	// ==================================================
	// compare, report, close
	task automatic chk(input string nm, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==================================================
	// ahb-lite single word transfers; the wait on hready has no fixed count
	task automatic xfer(input logic [7:0] a, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd_d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_d = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [31:0] x;
		xfer(a, 1'b1, v, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		xfer(a, 1'b0, 32'h00000000, v);
	endtask
	// read until one bit reaches a value, then compare it
	task automatic poll(input logic [7:0] a, input int b, input logic v,
		input string nm);
		logic [31:0] x;
		for (int i = 0; i < 300; i++)
		begin
			rd(a, x);
			if (x[b] === v)
				break;
		end
		chk(nm, {31'h0, x[b]}, {31'h0, v});
	endtask
	// flag writes carry the control bits; ones leave flags alone
	task automatic clr_flag(input int b);
		wr(RCC_OFF_IRQ, ctl | (32'hff & ~(32'h1 << b)));
	endtask
	task automatic pulse_reset(input logic por);
		@(posedge hclk);
		hresetn <= 1'b0;
		por_n   <= ~por;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		por_n   <= 1'b1;
		@(posedge hclk);
	endtask

	// ==================================================
	// main sequence
	initial
	begin
		seed = 32'h07bc89dc;
		n_mismatch = 0;
		check_count = 0;
		hresetn = 1'b0;
		por_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		ctl = 32'h00000000;
		pulse_reset(1'b1);
		// reset values and an unmapped word
		rd(RCC_OFF_IRQ, d); chk("ctrl rst", d, 32'h0);
		rd(RCC_OFF_TIMER, d); chk("timer rst", d, 32'h0);
		rd(RCC_OFF_SUBS, d); chk("subs rst", d, {8'h0, RCC_SUBS_RST});
		rd(RCC_OFF_TSET, d); chk("tset rst", d, {14'h0, RCC_TSET_RST});
		wr(8'h40, 32'hffffffff);
		rd(8'h40, d); chk("unmapped", d, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		$display("test reset done");
		// half-second pin: period 10 cycles gives 20 edges in 200
		wr(RCC_OFF_SUBS, 32'h9);
		ctl = 32'h1 << RCC_B_GO;
		wr(RCC_OFF_IRQ, ctl | 32'hff);
		repeat (30) @(posedge hclk);
		n = 0;
		p = half_sec_clk_out;
		repeat (200)
		begin
			@(posedge hclk);
			#1;
			if (half_sec_clk_out !== p)
				n++;
			p = half_sec_clk_out;
		end
		chk("pin edges", n, 20);
		$display("test pin done");
		// periodic flags with counting stopped so none races the clears
		ctl = 32'h0;
		wr(RCC_OFF_IRQ, 32'hff);
		rd(RCC_OFF_IRQ, d); chk("periodic flags", d & 32'h0f, 32'h03);
		ctl = 32'h1 << RCC_EN_SH;
		wr(RCC_OFF_IRQ, ctl | 32'hff);
		rd(RCC_OFF_IRQ, d); chk("one keeps", d & 32'h1, 32'h1);
		chk("irq on", {31'h0, irq}, 32'h1);
		clr_flag(RCC_B_HSEC);
		rd(RCC_OFF_IRQ, d); chk("zero clears", d & 32'h1, 32'h0);
		chk("irq off", {31'h0, irq}, 32'h0);
		ctl = 32'h1 << RCC_B_GO;
		wr(RCC_OFF_IRQ, ctl);
		$display("test flags done");
		// one-shot timer: fires after set+1 ticks of 10 cycles
		tset = 18'd3 + 18'($unsigned($random(seed)) % 4);
		wr(RCC_OFF_TSET, {14'h0, tset});
		wr(RCC_OFF_TIMER, 32'h1 << RCC_B_TGO);
		rd(RCC_OFF_TIMER, d); chk("timer start", d & 32'h700, 32'h500);
		repeat (20) @(posedge hclk);
		rd(RCC_OFF_TIMER, d); chk("still active", d & 32'h400, 32'h400);
		poll(RCC_OFF_TIMER, RCC_B_TACT, 1'b0, "oneshot idle");
		rd(RCC_OFF_TIMER, d); chk("go cleared", d & 32'h700, 32'h0);
		rd(RCC_OFF_IRQ, d); chk("timer flag", d & 32'h10, 32'h10);
		$display("test oneshot done");
		// periodic timer keeps reloading until stopped
		clr_flag(RCC_B_TMR);
		wr(RCC_OFF_TSET, 32'h1);
		wr(RCC_OFF_TIMER, 32'h1 << RCC_B_TMODE);
		wr(RCC_OFF_TIMER, 32'h3 << RCC_B_TGO);
		repeat (100) @(posedge hclk);
		rd(RCC_OFF_TIMER, d); chk("periodic run", d & 32'h700, 32'h700);
		clr_flag(RCC_B_TMR);
		poll(RCC_OFF_IRQ, RCC_B_TMR, 1'b1, "periodic again");
		wr(RCC_OFF_TIMER, 32'h1 << RCC_B_TMODE);
		poll(RCC_OFF_TIMER, RCC_B_TACT, 1'b0, "periodic stop");
		wr(RCC_OFF_TIMER, 32'h0);
		wr(RCC_OFF_IRQ, ctl);
		$display("test periodic done");
		// calendar rewrite with count reset, random legal time, second 0
		cal = {2'b0, 6'd1 + 6'($unsigned($random(seed)) % 28),
			2'b0, 6'($unsigned($random(seed)) % 24),
			1'b0, 7'($unsigned($random(seed)) % 59), 8'h00};
		wr(RCC_OFF_IRQ, ctl | (32'h1 << RCC_B_RSREQ));
		rd(RCC_OFF_IRQ, d); chk("busy set", d & 32'h4000, 32'h4000);
		wr(RCC_OFF_DHMS, cal);
		wr(RCC_OFF_IRQ, ctl);
		poll(RCC_OFF_IRQ, RCC_B_BUSY, 1'b0, "busy clear");
		// alarm: a minute apart stays quiet, exact match fires
		ctl = ctl | (32'h7 << RCC_B_AEN) | (32'h1 << (RCC_EN_SH + RCC_B_ALM));
		wr(RCC_OFF_ADHM, cal + 32'h100);
		wr(RCC_OFF_IRQ, ctl);
		repeat (30) @(posedge hclk);
		rd(RCC_OFF_IRQ, d); chk("alarm quiet", d & 32'h20, 32'h0);
		wr(RCC_OFF_ADHM, cal);
		repeat (5) @(posedge hclk);
		rd(RCC_OFF_IRQ, d); chk("alarm hit", d & 32'h20, 32'h20);
		chk("alarm irq", {31'h0, irq}, 32'h1);
		ctl = 32'h0;
		wr(RCC_OFF_IRQ, 32'h0);
		$display("test alarm done");
		// system reset keeps the calendar; capture reads it back
		pulse_reset(1'b0);
		rd(RCC_OFF_IRQ, d); chk("sys rst ctrl", d, 32'h0);
		wr(RCC_OFF_TIMER, 32'h1);
		poll(RCC_OFF_TIMER, RCC_B_CREQ, 1'b0, "capture done");
		rd(RCC_OFF_IRQ, d); chk("capture flag", d & 32'h80, 32'h80);
		rd(RCC_OFF_DHMS, d); chk("cal kept", d & 32'h3f3f7f00, cal);
		$display("test sysreset done");
		// power-on reset clears the calendar counters
		pulse_reset(1'b1);
		wr(RCC_OFF_TIMER, 32'h1);
		poll(RCC_OFF_TIMER, RCC_B_CREQ, 1'b0, "capture por");
		rd(RCC_OFF_DHMS, d); chk("cal cleared", d & 32'h3f3f7f00, 32'h0);
		$display("test por done");
		wrap_up();
	end
endmodule
`default_nettype wire
